/* File: pkg/drm_pkg.sv */
/*
 * drm_pkg: word width, select encodings, fixed constants and field
 * positions for the processor data routing multiplexers.
 * Assumes: 16-bit data section, select fields from microprogram control.
 */
package drm_pkg;

   // ************************************************************
   // widths
   // ************************************************************
   localparam int DW = 16;
   localparam int BYTE_W = 8;
   localparam int IBUS_DEVS = 4;
   localparam int IBUS_DEV_W = 2;
   localparam int CSW_W = 3;

   typedef logic [DW-1:0] drm_word_t;

   // ************************************************************
   // select encodings
   // ************************************************************
   typedef enum logic [1:0] {ASEL_SRC, ASEL_DST, ASEL_BUS, ASEL_PC} drm_asel_e;
   typedef enum logic [1:0] {BSEL_SRC, BSEL_BUS, BSEL_K0, BSEL_K1} drm_bsel_e;
   typedef enum logic [1:0] {K0_ONE, K0_TWO, K0_SRC, K0_DST} drm_k0_e;
   typedef enum logic [1:0] {K1_TRAP, K1_START, K1_LOOP, K1_BRANCH} drm_k1_e;
   typedef enum logic [1:0] {SHF_PASS, SHF_SWAP, SHF_SHR, SHF_PC} drm_shf_e;
   typedef enum logic {TR_GPR, TR_SHF} drm_trsel_e;
   typedef enum logic [1:0] {BRX_SHF, BRX_SYS, BRX_FAST, BRX_IBUS} drm_brsel_e;
   typedef enum logic [1:0] {BA_PC, BA_SRC, BA_DST, BA_EXP} drm_basel_e;
   typedef enum logic [1:0] {DOUT_BUS, DOUT_SHF, DOUT_PC, DOUT_AUX} drm_dout_e;
   typedef enum logic [1:0] {DISP_SHF, DISP_BUS, DISP_SRC, DISP_DST} drm_disp_e;

   // ************************************************************
   // constants and field positions
   // ************************************************************
   localparam drm_word_t K0_ONE_VAL = 16'h0001;
   localparam drm_word_t K0_TWO_VAL = 16'h0002;
   localparam drm_word_t START_VEC_DEF = 16'h0000;
   localparam int LOOP_OFS_MSB = 5;
   localparam int BRANCH_OFS_MSB = 7;
   localparam drm_word_t WORD_RST = 16'h0000;
   localparam logic [CSW_W-1:0] CSW_RST = 3'h0;
   // console switch bit positions
   localparam int CSW_DISP_LO = 0;
   localparam int CSW_DISP_HI = 1;
   localparam int CSW_ADDR_PHYS = 2;

endpackage : drm_pkg

/* File: pkg/drm_const_if.sv */
/*
 * drm_const_if: carries constant selector fields, their sources and
 * their two outputs between the routing top and the constant selector.
 * Assumes: purely combinational use on the single processor clock.
 */
`timescale 1ns/1ps
`default_nettype none

interface drm_const_if;
   import drm_pkg::*;
   drm_k0_e k0_sel;
   drm_k1_e k1_sel;
   drm_word_t bus_word;
   drm_word_t src_const;
   drm_word_t dst_const;
   drm_word_t trap_vec;
   drm_word_t k0_out;
   drm_word_t k1_out;

   modport user (output k0_sel, k1_sel, bus_word, src_const, dst_const, trap_vec,
                 input k0_out, k1_out);
   modport sel (input k0_sel, k1_sel, bus_word, src_const, dst_const, trap_vec,
                output k0_out, k1_out);
endinterface : drm_const_if

`default_nettype wire

/* File: core/drm_const_sel.sv */
/*
 * drm_const_sel: constant selectors zero and one feeding the B operand
 * selector. Assumes: select fields are stable for the machine cycle.
 */
`timescale 1ns/1ps
`default_nettype none

module drm_const_sel #(
   parameter drm_pkg::drm_word_t START_VEC = drm_pkg::START_VEC_DEF
) (
   drm_const_if.sel cif
);
   import drm_pkg::*;

   // ************************************************************
   // constant selector zero: fixed 1, fixed 2 or generated constants
   // ************************************************************
   always_comb begin
      unique case (cif.k0_sel)
         K0_ONE: cif.k0_out = K0_ONE_VAL;
         K0_TWO: cif.k0_out = K0_TWO_VAL;
         K0_SRC: cif.k0_out = cif.src_const;
         K0_DST: cif.k0_out = cif.dst_const;
      endcase
   end

   // ************************************************************
   // constant selector one: vectors or word offsets from bus reg
   // ************************************************************
   always_comb begin
      unique case (cif.k1_sel)
         K1_TRAP: cif.k1_out = cif.trap_vec;
         K1_START: cif.k1_out = START_VEC;
         // loop/mark offset: low bits doubled and sign-extended
         K1_LOOP: cif.k1_out = {{(DW-LOOP_OFS_MSB-2){cif.bus_word[LOOP_OFS_MSB]}},
                                cif.bus_word[LOOP_OFS_MSB:0], 1'b0};
         // branch offset: low byte doubled and sign-extended
         K1_BRANCH: cif.k1_out = {{(DW-BRANCH_OFS_MSB-2){cif.bus_word[BRANCH_OFS_MSB]}},
                                  cif.bus_word[BRANCH_OFS_MSB:0], 1'b0};
      endcase
   end

endmodule : drm_const_sel

`default_nettype wire

/* File: core/drm_datapath.sv */
/*
 * drm_datapath: operand and result routing of the processor data
 * section: ALU operand selectors, result shifter, temporary register
 * input selectors, bus address and data out selectors, internal bus
 * gating and console light selection.
 * Assumes: one processor clock; select fields and load strobes come
 * from microprogram control for the current cycle; console switches
 * are asynchronous pins; t3_pulse is a one-cycle pulse on clk.
 */
`timescale 1ns/1ps
`default_nettype none

module drm_datapath #(
   parameter drm_pkg::drm_word_t START_VEC = drm_pkg::START_VEC_DEF
) (
   input wire logic clk,
   input wire logic rst_n,
   // microprogram select fields
   input wire drm_pkg::drm_asel_e alu_a_select,
   input wire drm_pkg::drm_bsel_e alu_b_select,
   input wire drm_pkg::drm_k0_e const_select_zero,
   input wire drm_pkg::drm_k1_e const_select_one,
   input wire drm_pkg::drm_shf_e shift_op,
   input wire drm_pkg::drm_trsel_e source_temp_input_sel,
   input wire drm_pkg::drm_trsel_e dest_temp_input_sel,
   input wire drm_pkg::drm_brsel_e bus_temp_input_sel,
   input wire drm_pkg::drm_basel_e bus_address_select,
   input wire drm_pkg::drm_dout_e data_out_select,
   input wire drm_pkg::drm_disp_e disp_word_select,
   // load strobes
   input wire logic ld_source_temp,
   input wire logic ld_dest_temp,
   input wire logic ld_bus_temp,
   input wire logic ld_gpr,
   input wire logic ld_pc,
   input wire logic ld_bus_addr,
   input wire logic ld_sys_data,
   // data sources
   input wire drm_pkg::drm_word_t alu_result,
   input wire logic shift_in_bit,
   input wire drm_pkg::drm_word_t pc_value,
   input wire drm_pkg::drm_word_t gpr_source_port,
   input wire drm_pkg::drm_word_t gpr_dest_port,
   input wire drm_pkg::drm_word_t src_const,
   input wire drm_pkg::drm_word_t dst_const,
   input wire drm_pkg::drm_word_t trap_vec,
   input wire drm_pkg::drm_word_t fast_bus_input,
   input wire drm_pkg::drm_word_t internal_bus,
   input wire drm_pkg::drm_word_t sys_bus_data,
   input wire logic t3_pulse,
   input wire drm_pkg::drm_word_t exponent_arith_unit,
   input wire drm_pkg::drm_word_t data_out_aux,
   // internal bus control
   input wire logic ibus_drive,
   input wire logic ibus_load_req,
   input wire logic [drm_pkg::IBUS_DEV_W-1:0] ibus_dest,
   // console
   input wire logic [drm_pkg::CSW_W-1:0] console_sw,
   input wire logic mmu_present,
   input wire drm_pkg::drm_word_t mmu_phys_addr,
   // outputs
   output logic [drm_pkg::DW-1:0] alu_a_q,
   output logic [drm_pkg::DW-1:0] alu_b_q,
   output logic [drm_pkg::DW-1:0] source_temp_reg_q,
   output logic [drm_pkg::DW-1:0] dest_temp_reg_q,
   output logic [drm_pkg::DW-1:0] bus_temp_reg_q,
   output logic [drm_pkg::DW-1:0] gpr_wr_data_q,
   output logic gpr_wr_en_q,
   output logic [drm_pkg::DW-1:0] pc_wr_data_q,
   output logic pc_wr_en_q,
   output logic [drm_pkg::DW-1:0] bus_addr_q,
   output logic [drm_pkg::DW-1:0] sys_data_out_q,
   output logic ibus_oe_q,
   output logic [drm_pkg::IBUS_DEVS-1:0] ibus_load_q,
   output logic [drm_pkg::DW-1:0] disp_data_q,
   output logic [drm_pkg::DW-1:0] disp_addr_q
);
   import drm_pkg::*;

   // ************************************************************
   // declarations
   // ************************************************************
   drm_const_if cif ();
   drm_word_t shf_out;
   drm_word_t alu_a_d;
   drm_word_t alu_b_d;
   drm_word_t src_d;
   drm_word_t dst_d;
   drm_word_t bus_d;
   drm_word_t sysbuf_q;
   drm_word_t sysbuf_d;
   drm_word_t gpr_wr_data_d;
   logic gpr_wr_en_d;
   drm_word_t pc_wr_data_d;
   logic pc_wr_en_d;
   drm_word_t baddr_mux_out;
   drm_word_t bus_addr_d;
   drm_word_t sys_data_out_d;
   logic ibus_oe_d;
   logic [IBUS_DEVS-1:0] ibus_load_d;
   logic [IBUS_DEVS-1:0] dest_hit;
   drm_word_t disp_data_d;
   drm_word_t disp_addr_d;
   logic [CSW_W-1:0] sw_s1_q;
   logic [CSW_W-1:0] sw_s2_q;
   logic [CSW_W-1:0] sw_s3_q;
   logic [CSW_W-1:0] sw_q;
   logic [CSW_W-1:0] sw_s1_d;
   logic [CSW_W-1:0] sw_s2_d;
   logic [CSW_W-1:0] sw_s3_d;
   logic [CSW_W-1:0] sw_d;

   // ************************************************************
   // constant selectors
   // ************************************************************
   assign cif.k0_sel = const_select_zero;
   assign cif.k1_sel = const_select_one;
   assign cif.bus_word = bus_temp_reg_q;
   assign cif.src_const = src_const;
   assign cif.dst_const = dst_const;
   assign cif.trap_vec = trap_vec;

   drm_const_sel #(
      .START_VEC(START_VEC)
   ) u_const (
      .cif(cif.sel)
   );

   // ************************************************************
   // operand selectors and shifter
   // ************************************************************
   // A and B operand selection from current fields
   always_comb begin
      unique case (alu_a_select)
         ASEL_SRC: alu_a_d = source_temp_reg_q;
         ASEL_DST: alu_a_d = dest_temp_reg_q;
         ASEL_BUS: alu_a_d = bus_temp_reg_q;
         ASEL_PC: alu_a_d = pc_value;
      endcase
      unique case (alu_b_select)
         BSEL_SRC: alu_b_d = source_temp_reg_q;
         BSEL_BUS: alu_b_d = bus_temp_reg_q;
         BSEL_K0: alu_b_d = cif.k0_out;
         BSEL_K1: alu_b_d = cif.k1_out;
      endcase
   end

   // result shifter: pass, byte swap, right shift or PC substitute
   always_comb begin
      unique case (shift_op)
         SHF_PASS: shf_out = alu_result;
         SHF_SWAP: shf_out = {alu_result[BYTE_W-1:0], alu_result[DW-1:BYTE_W]};
         SHF_SHR: shf_out = {shift_in_bit, alu_result[DW-1:1]};
         SHF_PC: shf_out = pc_value;
      endcase
   end

   // ************************************************************
   // temporary register inputs and result paths
   // ************************************************************
   // each register holds unless its strobe is present
   always_comb begin
      src_d = source_temp_reg_q;
      dst_d = dest_temp_reg_q;
      bus_d = bus_temp_reg_q;
      sysbuf_d = sysbuf_q;
      if (ld_source_temp) begin
         src_d = (source_temp_input_sel == TR_GPR) ? gpr_source_port : shf_out;
      end
      if (ld_dest_temp) begin
         dst_d = (dest_temp_input_sel == TR_GPR) ? gpr_dest_port : shf_out;
      end
      // system bus word is buffered at every T3 pulse
      if (t3_pulse) begin
         sysbuf_d = sys_bus_data;
      end
      if (ld_bus_temp) begin
         unique case (bus_temp_input_sel)
            BRX_SHF: bus_d = shf_out;
            BRX_SYS: bus_d = sysbuf_q;
            BRX_FAST: bus_d = fast_bus_input;
            BRX_IBUS: bus_d = internal_bus;
         endcase
      end
   end

   // general register and PC write paths; PC bypasses the shifter
   always_comb begin
      gpr_wr_en_d = ld_gpr;
      gpr_wr_data_d = ld_gpr ? shf_out : gpr_wr_data_q;
      pc_wr_en_d = ld_pc;
      pc_wr_data_d = ld_pc ? alu_result : pc_wr_data_q;
   end

   // ************************************************************
   // external interface selectors
   // ************************************************************
   // bus address select; exponent input never reaches the bus address
   always_comb begin
      unique case (bus_address_select)
         BA_PC: baddr_mux_out = pc_value;
         BA_SRC: baddr_mux_out = source_temp_reg_q;
         BA_DST: baddr_mux_out = dest_temp_reg_q;
         BA_EXP: baddr_mux_out = exponent_arith_unit;
      endcase
      bus_addr_d = bus_addr_q;
      if (ld_bus_addr && (bus_address_select != BA_EXP)) begin
         bus_addr_d = baddr_mux_out;
      end
   end

   // outbound system bus data; fast/internal take bus_temp_reg_q directly
   always_comb begin
      sys_data_out_d = sys_data_out_q;
      if (ld_sys_data) begin
         unique case (data_out_select)
            DOUT_BUS: sys_data_out_d = bus_temp_reg_q;
            DOUT_SHF: sys_data_out_d = shf_out;
            DOUT_PC: sys_data_out_d = pc_value;
            DOUT_AUX: sys_data_out_d = data_out_aux;
         endcase
      end
   end

   // internal bus destination decode, one load per device
   genvar gi;
   generate
      for (gi = 0; gi < IBUS_DEVS; gi++) begin : g_dest
         assign dest_hit[gi] = (ibus_dest == IBUS_DEV_W'(gi));
      end
   endgenerate

   // internal bus: drive enable and load strobe, no address
   always_comb begin
      ibus_oe_d = ibus_drive;
      ibus_load_d = ibus_load_req ? dest_hit : '0;
   end

   // ************************************************************
   // console switch synchroniser
   // ************************************************************
   // three stages; the held value moves only when stages two and three agree
   always_comb begin
      sw_s1_d = console_sw;
      sw_s2_d = sw_s1_q;
      sw_s3_d = sw_s2_q;
      sw_d = (sw_s2_q == sw_s3_q) ? sw_s3_q : sw_q;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sw_s1_q <= CSW_RST;
         sw_s2_q <= CSW_RST;
         sw_s3_q <= CSW_RST;
         sw_q <= CSW_RST;
      end else begin
         sw_s1_q <= sw_s1_d;
         sw_s2_q <= sw_s2_d;
         sw_s3_q <= sw_s3_d;
         sw_q <= sw_d;
      end
   end

   // ************************************************************
   // console lights
   // ************************************************************
   // data word chosen by switches, address from selector or MMU
   always_comb begin
      unique case (drm_disp_e'(sw_q[CSW_DISP_HI:CSW_DISP_LO]))
         DISP_SHF: disp_data_d = shf_out;
         DISP_BUS: disp_data_d = bus_temp_reg_q;
         DISP_SRC: disp_data_d = source_temp_reg_q;
         DISP_DST: disp_data_d = dest_temp_reg_q;
      endcase
      if (sw_q[CSW_ADDR_PHYS] && mmu_present) begin
         disp_addr_d = mmu_phys_addr;
      end else begin
         disp_addr_d = baddr_mux_out;
      end
   end

   // ************************************************************
   // registers
   // ************************************************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         alu_a_q <= WORD_RST;
         alu_b_q <= WORD_RST;
         source_temp_reg_q <= WORD_RST;
         dest_temp_reg_q <= WORD_RST;
         bus_temp_reg_q <= WORD_RST;
         sysbuf_q <= WORD_RST;
         gpr_wr_data_q <= WORD_RST;
         gpr_wr_en_q <= 1'b0;
         pc_wr_data_q <= WORD_RST;
         pc_wr_en_q <= 1'b0;
         bus_addr_q <= WORD_RST;
         sys_data_out_q <= WORD_RST;
         ibus_oe_q <= 1'b0;
         ibus_load_q <= '0;
         disp_data_q <= WORD_RST;
         disp_addr_q <= WORD_RST;
      end else begin
         alu_a_q <= alu_a_d;
         alu_b_q <= alu_b_d;
         source_temp_reg_q <= src_d;
         dest_temp_reg_q <= dst_d;
         bus_temp_reg_q <= bus_d;
         sysbuf_q <= sysbuf_d;
         gpr_wr_data_q <= gpr_wr_data_d;
         gpr_wr_en_q <= gpr_wr_en_d;
         pc_wr_data_q <= pc_wr_data_d;
         pc_wr_en_q <= pc_wr_en_d;
         bus_addr_q <= bus_addr_d;
         sys_data_out_q <= sys_data_out_d;
         ibus_oe_q <= ibus_oe_d;
         ibus_load_q <= ibus_load_d;
         disp_data_q <= disp_data_d;
         disp_addr_q <= disp_addr_d;
      end
   end

endmodule : drm_datapath

`default_nettype wire

/* File: dv/drm_route_props.sv */
/*
 * drm_route_props: assertions on the routing top's ports.
 * Assumes: bound into drm_datapath, one clock, async active-low reset.
 */
`timescale 1ns/1ps
`default_nettype none

module drm_route_props (
   input wire logic clk,
   input wire logic rst_n,
   input wire drm_pkg::drm_asel_e alu_a_select,
   input wire drm_pkg::drm_trsel_e source_temp_input_sel,
   input wire drm_pkg::drm_brsel_e bus_temp_input_sel,
   input wire drm_pkg::drm_basel_e bus_address_select,
   input wire logic ld_source_temp,
   input wire logic ld_dest_temp,
   input wire logic ld_bus_temp,
   input wire logic ld_pc,
   input wire logic ld_bus_addr,
   input wire logic t3_pulse,
   input wire logic ibus_load_req,
   input wire logic [drm_pkg::IBUS_DEV_W-1:0] ibus_dest,
   input wire drm_pkg::drm_word_t pc_value,
   input wire drm_pkg::drm_word_t alu_result,
   input wire drm_pkg::drm_word_t gpr_source_port,
   input wire drm_pkg::drm_word_t sys_bus_data,
   input wire logic [drm_pkg::DW-1:0] alu_a_q,
   input wire logic [drm_pkg::DW-1:0] source_temp_reg_q,
   input wire logic [drm_pkg::DW-1:0] dest_temp_reg_q,
   input wire logic [drm_pkg::DW-1:0] bus_temp_reg_q,
   input wire logic [drm_pkg::DW-1:0] pc_wr_data_q,
   input wire logic pc_wr_en_q,
   input wire logic [drm_pkg::DW-1:0] bus_addr_q,
   input wire logic [drm_pkg::IBUS_DEVS-1:0] ibus_load_q
);
   import drm_pkg::*;

   // ************************************************************
   // routing properties
   // ************************************************************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   // system bus word caught at T3, then taken into the bus register
   sequence t3_capture;
      t3_pulse;
   endsequence
   sequence sys_load;
      ld_bus_temp && bus_temp_input_sel == BRX_SYS;
   endsequence

   chk_a_pc_pick: assert property (
      alu_a_select == ASEL_PC |=> alu_a_q == $past(pc_value)) else $error("a operand not pc");
   chk_a_src_pick: assert property (
      alu_a_select == ASEL_SRC |=> alu_a_q == $past(source_temp_reg_q))
      else $error("a operand not source register");
   chk_pc_no_shift: assert property (
      ld_pc |=> pc_wr_en_q && pc_wr_data_q == $past(alu_result)) else $error("pc write altered");
   chk_src_from_gpr: assert property (
      ld_source_temp && source_temp_input_sel == TR_GPR |=>
      source_temp_reg_q == $past(gpr_source_port)) else $error("source register load wrong");
   chk_dst_hold: assert property (
      !ld_dest_temp |=> $stable(dest_temp_reg_q)) else $error("dest register changed unloaded");
   chk_exp_no_addr: assert property (
      ld_bus_addr && bus_address_select == BA_EXP |=> $stable(bus_addr_q))
      else $error("exponent reached bus address");
   chk_ibus_one_load: assert property (
      1'b1 |=> ibus_load_q == ($past(ibus_load_req) ? 4'h1 << $past(ibus_dest) : 4'h0))
      else $error("internal bus load strobes wrong");
   chk_sys_buffered: assert property (
      t3_capture ##1 sys_load |=> bus_temp_reg_q == $past(sys_bus_data, 2))
      else $error("system bus word not from t3 buffer");
endmodule : drm_route_props

bind drm_datapath drm_route_props drm_route_props_inst (
   .clk, .rst_n, .alu_a_select, .source_temp_input_sel, .bus_temp_input_sel,
   .bus_address_select, .ld_source_temp, .ld_dest_temp, .ld_bus_temp, .ld_pc, .ld_bus_addr,
   .t3_pulse, .ibus_load_req, .ibus_dest, .pc_value, .alu_result, .gpr_source_port,
   .sys_bus_data, .alu_a_q, .source_temp_reg_q, .dest_temp_reg_q, .bus_temp_reg_q,
   .pc_wr_data_q, .pc_wr_en_q, .bus_addr_q, .ibus_load_q
);

`default_nettype wire

/* File: dv/drm_bus_model.sv */
/*
 * drm_bus_model: far side stand-in giving the T3 pulse and the inbound
 * bus words. Assumes: one clock; changes 1 ns after each rising edge.
 */
`timescale 1ns/1ps
`default_nettype none

module drm_bus_model (
   input wire logic clk,
   output var logic t3_pulse,
   output var drm_pkg::drm_word_t sys_bus_data,
   output var drm_pkg::drm_word_t fast_bus_input,
   output var drm_pkg::drm_word_t internal_bus
);
   import drm_pkg::*;
   logic [1:0] phase = 2'h0;

   // ************************************************************
   // time pulses and bus words
   // ************************************************************
   initial begin
      t3_pulse = 1'b0;
      sys_bus_data = 16'h1234;
   end
   // T3 every fourth cycle; the word keeps moving so a stale capture shows
   always @(posedge clk) begin
      #1;
      phase = phase + 2'h1;
      t3_pulse = phase == 2'h3;
      sys_bus_data = sys_bus_data * 16'h0005 + 16'h3b1d;
   end
   // other senders put their own words on the fast and internal buses
   assign fast_bus_input = {sys_bus_data[7:0], ~sys_bus_data[15:8]};
   assign internal_bus = ~sys_bus_data;
endmodule : drm_bus_model

`default_nettype wire

/* File: dv/test_cpu_datapath_routing_muxes.sv */
/*
 * test_cpu_datapath_routing_muxes: random microwords checked against a
 * bench model, then console light and reset corners.
 * Assumes: drm_datapath with default start vector, drm_bus_model far side.
 */
`timescale 1ns/1ps
`default_nettype none

module test_cpu_datapath_routing_muxes;
   import drm_pkg::*;

   logic clk, rst_n, ld_source_temp, ld_dest_temp, ld_bus_temp, ld_gpr, ld_pc, ld_bus_addr;
   logic ld_sys_data, shift_in_bit, ibus_drive, ibus_load_req, mmu_present, t3_pulse;
   logic gpr_wr_en_q, pc_wr_en_q, ibus_oe_q, e_ge, e_pe, e_oe;
   logic [1:0] ibus_dest;
   logic [2:0] console_sw;
   logic [3:0] ibus_load_q, e_ld;
   drm_asel_e alu_a_select;
   drm_bsel_e alu_b_select;
   drm_k0_e const_select_zero;
   drm_k1_e const_select_one;
   drm_shf_e shift_op;
   drm_trsel_e source_temp_input_sel, dest_temp_input_sel;
   drm_brsel_e bus_temp_input_sel;
   drm_basel_e bus_address_select;
   drm_dout_e data_out_select;
   drm_disp_e disp_word_select;
   drm_word_t alu_result, pc_value, gpr_source_port, gpr_dest_port, src_const, dst_const;
   drm_word_t trap_vec, exponent_arith_unit, data_out_aux, mmu_phys_addr;
   drm_word_t fast_bus_input, internal_bus, sys_bus_data, alu_a_q, alu_b_q;
   drm_word_t source_temp_reg_q, dest_temp_reg_q, bus_temp_reg_q, gpr_wr_data_q;
   drm_word_t pc_wr_data_q, bus_addr_q, sys_data_out_q, disp_data_q, disp_addr_q;
   // expected outputs and the bench's copy of the T3 buffer
   drm_word_t e_a, e_b, e_src, e_dst, e_bus, e_gw, e_pd, e_ba, e_so, sbuf, dw[4];
   int fails, n_checks;

   drm_datapath drm_datapath_inst (.*);
   drm_bus_model drm_bus_model_inst (.*);

   initial clk = 1'b0;
   always #12.5 clk = ~clk;

   // ************************************************************
   // reference model and checking
   // ************************************************************
   function automatic drm_word_t shf(drm_shf_e op, drm_word_t r, logic si, drm_word_t pc);
      drm_word_t v[4];
      v = '{r, {r[7:0], r[15:8]}, {si, r[15:1]}, pc};
      return v[op];
   endfunction : shf

   task automatic predict();
      drm_word_t sh, av[4], bv[4], k0v[4], k1v[4], brv[4], bav[4], dv[4];
      sh = shf(shift_op, alu_result, shift_in_bit, pc_value);
      k0v = '{K0_ONE_VAL, K0_TWO_VAL, src_const, dst_const};
      k1v = '{trap_vec, START_VEC_DEF, {{9{e_bus[5]}}, e_bus[5:0], 1'b0},
              {{7{e_bus[7]}}, e_bus[7:0], 1'b0}};
      av = '{e_src, e_dst, e_bus, pc_value};
      bv = '{e_src, e_bus, k0v[const_select_zero], k1v[const_select_one]};
      brv = '{sh, sbuf, fast_bus_input, internal_bus};
      bav = '{pc_value, e_src, e_dst, e_ba};
      dv = '{e_bus, sh, pc_value, data_out_aux};
      e_a = av[alu_a_select];
      e_b = bv[alu_b_select];
      if (ld_source_temp) e_src = source_temp_input_sel == TR_GPR ? gpr_source_port : sh;
      if (ld_dest_temp) e_dst = dest_temp_input_sel == TR_GPR ? gpr_dest_port : sh;
      if (ld_bus_temp) e_bus = brv[bus_temp_input_sel];
      if (ld_bus_addr) e_ba = bav[bus_address_select];
      if (ld_sys_data) e_so = dv[data_out_select];
      if (ld_gpr) e_gw = sh;
      if (ld_pc) e_pd = alu_result;
      if (t3_pulse) sbuf = sys_bus_data;
      {e_ge, e_pe, e_oe} = {ld_gpr, ld_pc, ibus_drive};
      e_ld = ibus_load_req ? 4'h1 << ibus_dest : 4'h0;
   endtask : predict

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic check_all();
      chk(alu_a_q, e_a);
      chk(alu_b_q, e_b);
      chk(source_temp_reg_q, e_src);
      chk(dest_temp_reg_q, e_dst);
      chk(bus_temp_reg_q, e_bus);
      chk(gpr_wr_data_q, e_gw);
      chk(pc_wr_data_q, e_pd);
      chk(bus_addr_q, e_ba);
      chk(sys_data_out_q, e_so);
      chk({gpr_wr_en_q, pc_wr_en_q, ibus_oe_q, 9'h0, ibus_load_q}, {e_ge, e_pe, e_oe, 9'h0, e_ld});
   endtask : check_all

   // a fresh microword and fresh data words, with a sign-bit corner now and then
   task automatic rand_in();
      logic [31:0] r;
      r = $urandom;
      alu_a_select = drm_asel_e'(r[1:0]);
      alu_b_select = drm_bsel_e'(r[3:2]);
      const_select_zero = drm_k0_e'(r[5:4]);
      const_select_one = drm_k1_e'(r[7:6]);
      shift_op = drm_shf_e'(r[9:8]);
      source_temp_input_sel = drm_trsel_e'(r[10]);
      dest_temp_input_sel = drm_trsel_e'(r[11]);
      bus_temp_input_sel = drm_brsel_e'(r[13:12]);
      bus_address_select = drm_basel_e'(r[15:14]);
      data_out_select = drm_dout_e'(r[17:16]);
      {ld_source_temp, ld_dest_temp, ld_bus_temp, ld_gpr, ld_pc, ld_bus_addr, ld_sys_data,
       shift_in_bit, ibus_drive, ibus_load_req, ibus_dest} = r[29:18];
      {alu_result, pc_value} = $urandom;
      {gpr_source_port, gpr_dest_port} = $urandom;
      {src_const, dst_const} = $urandom;
      {trap_vec, exponent_arith_unit} = $urandom;
      {data_out_aux, mmu_phys_addr} = $urandom;
      if (r[31]) alu_result = 16'h80ff;
   endtask : rand_in

   task automatic complete_run();
      $display("checks %0d, mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : complete_run

   // ************************************************************
   // sequence of tests
   // ************************************************************
   initial begin
      void'($urandom(32'h2b6b));
      {fails, n_checks, rst_n, console_sw, mmu_present} = '0;
      disp_word_select = DISP_SHF;
      rand_in();
      {e_a, e_b, e_src, e_dst, e_bus, e_gw, e_pd, e_ba, e_so, sbuf, e_ge, e_pe, e_oe, e_ld} = '0;
      repeat (2) @(posedge clk);
      #2;
      rst_n = 1'b1;
      predict();
      repeat (300) begin
         @(posedge clk);
         #2;
         check_all();
         rand_in();
         predict();
      end
      @(posedge clk);
      #2;
      check_all();
      // hold the path still and step through every console switch setting
      {ld_source_temp, ld_dest_temp, ld_bus_temp, ld_gpr, ld_pc, ld_bus_addr, ld_sys_data} = '0;
      shift_op = SHF_PASS;
      bus_address_select = BA_EXP;
      mmu_present = 1'b1;
      for (int k = 0; k < 8; k++) begin
         console_sw = 3'(k);
         repeat (6) @(posedge clk);
         #2;
         dw = '{alu_result, e_bus, e_src, e_dst};
         chk(disp_data_q, dw[k % 4]);
         chk(disp_addr_q, k > 3 ? mmu_phys_addr : exponent_arith_unit);
      end
      // reset in mid-run clears registers without waiting for an edge
      rst_n = 1'b0;
      #3;
      chk(bus_temp_reg_q, WORD_RST);
      complete_run();
   end

   // cut a hang short: the run needs under 400 cycles
   initial begin
      #25000;
      fails++;
      complete_run();
   end
endmodule : test_cpu_datapath_routing_muxes

`default_nettype wire
